/* File: rtl/xgapt_map.svh */
// Register offsets, field positions, reset values and timing counts of the panel host
`ifndef XGAPT_MAP_SVH
`define XGAPT_MAP_SVH
`define XGAPT_REG_CTRL 4'h0
`define XGAPT_REG_DUTY 4'h4
`define XGAPT_REG_COLOUR 4'h8
`define XGAPT_REG_STATUS 4'hC
`define XGAPT_CTRL_POWER 0
`define XGAPT_CTRL_DEPTH8 1
`define XGAPT_CTRL_REVERSE 2
`define XGAPT_CTRL_RESET 3'h0
`define XGAPT_DUTY_RESET 7'h32
`define XGAPT_DUTY_MIN 7'h05
`define XGAPT_DUTY_MAX 7'h64
`define XGAPT_COLOUR_RESET 24'h000000
`define XGAPT_LINE_TOTAL 11'h540
`define XGAPT_LINE_ACTIVE 11'h400
`define XGAPT_HSYNC_START 11'h418
`define XGAPT_HSYNC_END 11'h4A0
`define XGAPT_FRAME_TOTAL_LINES 10'h326
`define XGAPT_FRAME_ACTIVE_LINES 10'h300
`define XGAPT_VSYNC_START 10'h303
`define XGAPT_VSYNC_END 10'h309
`define XGAPT_CLK_PERIOD_NS 100
`define XGAPT_MS_NS 1000000
`define XGAPT_PWM_STEPS 7'h64
`define XGAPT_PWM_PERIOD_MS 2
`define XGAPT_POWER_TO_VIDEO_DELAY_MS 9'h023
`define XGAPT_VIDEO_TO_PWM_MS 9'h0BE
`define XGAPT_PWM_TO_BACKLIGHT_ENABLE_DELAY_MS 9'h00A
`define XGAPT_VIDEO_OFF_TO_POWER_OFF_DELAY_MS 9'h00A
`define XGAPT_POWER_OFF_TO_BACKLIGHT_OFF_MS 9'h0BE
`define XGAPT_BACKLIGHT_OFF_TO_PWM_OFF_DELAY_MS 9'h001
`define XGAPT_PWM_OFF_TO_SUPPLY_OFF_MS 9'h001
`define XGAPT_RESTART_OFF_TIME_MS 9'h1F4
`endif

/* File: rtl/xgapt_pkg.sv */
// Types shared by the panel host
package xgapt_pkg;
  typedef enum logic [3:0] {
    XGAPT_OFF = 4'h0,
    XGAPT_VDD_UP = 4'h1,
    XGAPT_VIDEO = 4'h3,
    XGAPT_PWM_UP = 4'h2,
    XGAPT_RUN = 4'h6,
    XGAPT_VID_DN = 4'h7,
    XGAPT_VDD_DN = 4'h5,
    XGAPT_BL_DN = 4'h4,
    XGAPT_PWM_DN = 4'hC,
    XGAPT_RESTART = 4'hD
  } xgapt_state_t;

  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } xgapt_video_t;

  typedef struct packed {
    logic vdd_en;
    logic led_vin_en;
    logic pwm;
    logic bl_en;
  } xgapt_power_t;
endpackage : xgapt_pkg

/* File: rtl/xgapt_host.sv */
// Host controller for the 1024x768 panel: timing, power and backlight sequencing
`timescale 1ns/1ps
`include "xgapt_map.svh"

module xgapt_host #(
  parameter int MS_CYCLES = `XGAPT_MS_NS / `XGAPT_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Panel link
  output logic pix_clk_out,
  output xgapt_pkg::xgapt_video_t video_out,
  output logic colour_depth_select_out,
  output logic scan_reverse_select_out,
  // Power and backlight
  output xgapt_pkg::xgapt_power_t power_out
);
  import xgapt_pkg::*;

  // Dimming step: one period lasts 2 ms, a step never below one cycle
  localparam int PWM_STEP_RAW = MS_CYCLES * `XGAPT_PWM_PERIOD_MS / `XGAPT_PWM_STEPS;
  localparam int PWM_STEP_CYCLES = (PWM_STEP_RAW > 0) ? PWM_STEP_RAW : 1;

  logic [2:0] ctrl_reg;
  logic [6:0] duty_reg;
  logic [23:0] colour_reg;
  logic [6:0] duty_next;
  logic wb_req;
  logic wb_wr;
  xgapt_state_t state_reg;
  xgapt_state_t state_next;
  logic [15:0] pre_reg;
  logic [8:0] ms_reg;
  logic [8:0] delay_ms;
  logic done;
  logic vid_on;
  logic [10:0] h_reg;
  logic [9:0] v_reg;
  logic [15:0] frame_reg;
  logic pix_adv;
  logic [15:0] step_pre_reg;
  logic [6:0] step_reg;
  logic pwm_run;

  // Bus handshake
  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wb_wr = wb_req & wb_we_in;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
    end else if (ce_in) begin
      wb_ack_out <= wb_req;
    end
  end

  // Read data
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wb_dat_out <= 32'h00000000;
    end else if (ce_in) begin
      if (!wb_req) begin
        wb_dat_out <= 32'h00000000;
      end else if (wb_adr_in == `XGAPT_REG_CTRL) begin
        wb_dat_out <= {29'h00000000, ctrl_reg};
      end else if (wb_adr_in == `XGAPT_REG_DUTY) begin
        wb_dat_out <= {25'h0000000, duty_reg};
      end else if (wb_adr_in == `XGAPT_REG_COLOUR) begin
        wb_dat_out <= {8'h00, colour_reg};
      end else if (wb_adr_in == `XGAPT_REG_STATUS) begin
        wb_dat_out <= {frame_reg, 7'h00, vid_on, power_out, state_reg};
      end else begin
        wb_dat_out <= 32'h00000000;
      end
    end
  end

  // Control register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= `XGAPT_CTRL_RESET;
    end else if (ce_in && wb_wr && wb_sel_in[0] && wb_adr_in == `XGAPT_REG_CTRL) begin
      ctrl_reg <= wb_dat_in[2:0];
    end
  end

  always_comb begin
    duty_next = wb_dat_in[6:0];
    if (wb_dat_in[6:0] < `XGAPT_DUTY_MIN) begin
      duty_next = `XGAPT_DUTY_MIN;
    end else if (wb_dat_in[6:0] > `XGAPT_DUTY_MAX) begin
      duty_next = `XGAPT_DUTY_MAX;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      duty_reg <= `XGAPT_DUTY_RESET;
    end else if (ce_in && wb_wr && wb_sel_in[0] && wb_adr_in == `XGAPT_REG_DUTY) begin
      duty_reg <= duty_next;
    end
  end

  // Fill colour, one byte lane each
  for (genvar b = 0; b < 3; b++) begin : g_colour
    always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
        colour_reg[b*8 +: 8] <= 8'(`XGAPT_COLOUR_RESET >> (b * 8));
      end else if (ce_in && wb_wr && wb_sel_in[b] && wb_adr_in == `XGAPT_REG_COLOUR) begin
        colour_reg[b*8 +: 8] <= wb_dat_in[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pre_reg <= 16'h0000;
      ms_reg <= 9'h000;
    end else if (ce_in) begin
      if (state_reg != state_next) begin
        pre_reg <= 16'h0000;
        ms_reg <= 9'h000;
      end else if (pre_reg == 16'(MS_CYCLES - 1)) begin
        pre_reg <= 16'h0000;
        if (ms_reg != 9'h1FF) begin
          ms_reg <= ms_reg + 9'h001;
        end
      end else begin
        pre_reg <= pre_reg + 16'h0001;
      end
    end
  end

  always_comb begin
    case (state_reg)
      XGAPT_VDD_UP: delay_ms = `XGAPT_POWER_TO_VIDEO_DELAY_MS;
      XGAPT_VIDEO: delay_ms = `XGAPT_VIDEO_TO_PWM_MS;
      XGAPT_PWM_UP: delay_ms = `XGAPT_PWM_TO_BACKLIGHT_ENABLE_DELAY_MS;
      XGAPT_VID_DN: delay_ms = `XGAPT_VIDEO_OFF_TO_POWER_OFF_DELAY_MS;
      XGAPT_VDD_DN: delay_ms = `XGAPT_POWER_OFF_TO_BACKLIGHT_OFF_MS;
      XGAPT_BL_DN: delay_ms = `XGAPT_BACKLIGHT_OFF_TO_PWM_OFF_DELAY_MS;
      XGAPT_PWM_DN: delay_ms = `XGAPT_PWM_OFF_TO_SUPPLY_OFF_MS;
      XGAPT_RESTART: delay_ms = `XGAPT_RESTART_OFF_TIME_MS;
      default: delay_ms = 9'h000;
    endcase
  end

  assign done = ms_reg >= delay_ms;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      XGAPT_OFF: if (ctrl_reg[`XGAPT_CTRL_POWER]) state_next = XGAPT_VDD_UP;
      XGAPT_VDD_UP: if (done) state_next = XGAPT_VIDEO;
      XGAPT_VIDEO: if (done) state_next = XGAPT_PWM_UP;
      XGAPT_PWM_UP: if (done) state_next = XGAPT_RUN;
      XGAPT_RUN: if (!ctrl_reg[`XGAPT_CTRL_POWER]) state_next = XGAPT_VID_DN;
      XGAPT_VID_DN: if (done) state_next = XGAPT_VDD_DN;
      XGAPT_VDD_DN: if (done) state_next = XGAPT_BL_DN;
      XGAPT_BL_DN: if (done) state_next = XGAPT_PWM_DN;
      XGAPT_PWM_DN: if (done) state_next = XGAPT_RESTART;
      XGAPT_RESTART: if (done) state_next = XGAPT_OFF;
      default: state_next = XGAPT_RESTART;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= XGAPT_RESTART;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign vid_on = (state_reg == XGAPT_VIDEO) || (state_reg == XGAPT_PWM_UP) || (state_reg == XGAPT_RUN);
  assign pwm_run = (state_next == XGAPT_PWM_UP) || (state_next == XGAPT_RUN) || (state_next == XGAPT_VID_DN)
    || (state_next == XGAPT_VDD_DN) || (state_next == XGAPT_BL_DN);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      step_pre_reg <= 16'h0000;
      step_reg <= 7'h00;
    end else if (ce_in) begin
      if (step_pre_reg == 16'(PWM_STEP_CYCLES - 1)) begin
        step_pre_reg <= 16'h0000;
        step_reg <= (step_reg == `XGAPT_PWM_STEPS - 7'h01) ? 7'h00 : step_reg + 7'h01;
      end else begin
        step_pre_reg <= step_pre_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      power_out <= '0;
    end else if (ce_in) begin
      power_out.vdd_en <= (state_next == XGAPT_VDD_UP) || (state_next == XGAPT_VIDEO)
        || (state_next == XGAPT_PWM_UP) || (state_next == XGAPT_RUN) || (state_next == XGAPT_VID_DN);
      power_out.led_vin_en <= pwm_run || (state_next == XGAPT_VIDEO) || (state_next == XGAPT_PWM_DN);
      power_out.pwm <= pwm_run && (step_reg < duty_reg);
      power_out.bl_en <= (state_next == XGAPT_RUN) || (state_next == XGAPT_VID_DN)
        || (state_next == XGAPT_VDD_DN);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pix_clk_out <= 1'b0;
    end else if (ce_in) begin
      pix_clk_out <= vid_on & ~pix_clk_out;
    end
  end

  assign pix_adv = pix_clk_out;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      h_reg <= 11'h000;
      v_reg <= 10'h000;
      frame_reg <= 16'h0000;
    end else if (ce_in) begin
      if (!vid_on) begin
        h_reg <= 11'h000;
        v_reg <= 10'h000;
      end else if (pix_adv) begin
        if (h_reg == `XGAPT_LINE_TOTAL - 11'h001) begin
          h_reg <= 11'h000;
          if (v_reg == `XGAPT_FRAME_TOTAL_LINES - 10'h001) begin
            v_reg <= 10'h000;
            frame_reg <= frame_reg + 16'h0001;
          end else begin
            v_reg <= v_reg + 10'h001;
          end
        end else begin
          h_reg <= h_reg + 11'h001;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      video_out <= '0;
    end else if (ce_in) begin
      if (!vid_on) begin
        video_out <= '0;
      end else if (pix_adv) begin
        video_out.de <= (h_reg < `XGAPT_LINE_ACTIVE) && (v_reg < `XGAPT_FRAME_ACTIVE_LINES);
        video_out.hs <= (h_reg >= `XGAPT_HSYNC_START) && (h_reg < `XGAPT_HSYNC_END);
        video_out.vs <= (v_reg >= `XGAPT_VSYNC_START) && (v_reg < `XGAPT_VSYNC_END);
        if ((h_reg < `XGAPT_LINE_ACTIVE) && (v_reg < `XGAPT_FRAME_ACTIVE_LINES)) begin
          // low bits dropped in 6-bit mode
          if (ctrl_reg[`XGAPT_CTRL_DEPTH8]) begin
            video_out.red <= colour_reg[23:16];
            video_out.green <= colour_reg[15:8];
            video_out.blue <= colour_reg[7:0];
          end else begin
            video_out.red <= {colour_reg[23:18], 2'h0};
            video_out.green <= {colour_reg[15:10], 2'h0};
            video_out.blue <= {colour_reg[7:2], 2'h0};
          end
        end else begin
          video_out.red <= 8'h00;
          video_out.green <= 8'h00;
          video_out.blue <= 8'h00;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      colour_depth_select_out <= 1'b0;
      scan_reverse_select_out <= 1'b0;
    end else if (ce_in) begin
      colour_depth_select_out <= vid_on & ctrl_reg[`XGAPT_CTRL_DEPTH8];
      scan_reverse_select_out <= vid_on & ctrl_reg[`XGAPT_CTRL_REVERSE];
    end
  end

  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  de_in_active_a: assert property (ce_in && vid_on && pix_adv |=> video_out.de
    == ($past(h_reg) < `XGAPT_LINE_ACTIVE && $past(v_reg) < `XGAPT_FRAME_ACTIVE_LINES))
    else $error("data-enable outside active area");
  line_wrap_a: assert property (h_reg < `XGAPT_LINE_TOTAL && v_reg < `XGAPT_FRAME_TOTAL_LINES)
    else $error("line or frame counter out of range");
  supply_off_quiet_a: assert property (!power_out.vdd_en |=> !video_out.de && !pix_clk_out)
    else $error("link active with supply off");
  enable_after_pwm_a: assert property ($rose(power_out.bl_en) |-> $past(state_reg) == XGAPT_PWM_UP
    && $past(pwm_run) && $past(ms_reg) == `XGAPT_PWM_TO_BACKLIGHT_ENABLE_DELAY_MS)
    else $error("backlight enabled before PWM delay");
  video_start_a: assert property (state_reg == XGAPT_VIDEO && $past(state_reg) == XGAPT_VDD_UP
    |-> $past(ms_reg) == `XGAPT_POWER_TO_VIDEO_DELAY_MS)
    else $error("video started at wrong delay");
  restart_wait_a: assert property ($rose(power_out.vdd_en) |-> $past(state_reg) == XGAPT_OFF)
    else $error("supply restarted without off time");
  bl_off_first_a: assert property ($fell(power_out.pwm) && !pwm_run |-> !power_out.bl_en)
    else $error("PWM stopped with backlight enabled");
  pwm_before_supply_a: assert property ($fell(power_out.led_vin_en) |-> $past(!pwm_run, 2))
    else $error("backlight supply fell with PWM running");
  duty_range_a: assert property (duty_reg >= `XGAPT_DUTY_MIN && duty_reg <= `XGAPT_DUTY_MAX)
    else $error("duty outside range");
  supply_after_video_a: assert property ($fell(power_out.vdd_en) |-> $past(state_reg) == XGAPT_VID_DN
    && $past(ms_reg) == `XGAPT_VIDEO_OFF_TO_POWER_OFF_DELAY_MS)
    else $error("supply removed at wrong delay");

  run_reached_c: cover property (state_reg == XGAPT_PWM_UP ##1 state_reg == XGAPT_RUN);
  power_down_c: cover property (state_reg == XGAPT_PWM_DN ##1 state_reg == XGAPT_RESTART);
  frame_wrap_c: cover property ($changed(frame_reg));
  duty_write_c: cover property (wb_wr && wb_adr_in == `XGAPT_REG_DUTY);
endmodule : xgapt_host

/* File: dv/xgapt_panel_model.sv */
// Panel model: recovers line timing from data-enable and watches the quiet lines
`timescale 1ns/1ps
module xgapt_panel_model (
  // Clock
  input wire logic mclk_in,
  // Link and power from the host
  input wire logic pix_clk_in,
  input wire xgapt_pkg::xgapt_video_t video_in,
  input wire xgapt_pkg::xgapt_power_t power_in,
  // Measured timing, supply violations and colour
  output int de_len_out,
  output int line_len_out,
  output int lines_out,
  output int viol_out,
  output logic [23:0] rgb_out
);
  import xgapt_pkg::*;
  int run;
  int pix;
  logic de_q = 1'b0;
  always @(posedge mclk_in) begin
    if (power_in.vdd_en === 1'b0 && {video_in, pix_clk_in} !== '0) viol_out++;
    if (pix_clk_in === 1'b1) begin
      if (video_in.de && !de_q) begin
        line_len_out = pix;
        pix = 0;
      end
      if (video_in.de) begin
        run++;
        rgb_out = {video_in.red, video_in.green, video_in.blue};
      end
      if (!video_in.de && de_q) begin
        de_len_out = run;
        run = 0;
        lines_out++;
      end
      de_q = video_in.de;
      pix++;
    end
  end
endmodule : xgapt_panel_model

/* File: dv/tb.sv */
// Testbench for the panel host with a panel model and a register model
`timescale 1ns/1ps
module tb;
  import xgapt_pkg::*;
  localparam int MS = 50;
  localparam int PWM_PER = 2 * MS;
  localparam int LIMIT = 80000;
  logic mclk_in, rst_n_in, ce_in, cyc, stb, we, ack, pix, dsel, rsel;
  logic [3:0] adr, sel, r, f;
  logic [31:0] dat, rdat, rd;
  logic [23:0] rgb;
  logic [31:0] m[4];
  logic [31:0] duty_v[7];
  xgapt_video_t video;
  xgapt_power_t pw, pp;
  bit [31:0] seed = 24;
  int err_count, cmp_count, cyc_n, t_rel, hi, ln0, de_len, line_len, lines, viol;
  int t_vdd_on, t_vdd_off, t_led_on, t_led_off, t_pwm_on, t_pwm_last, t_bl_on, t_bl_off, t_vid_on, t_vid_last;

  xgapt_host #(.MS_CYCLES(MS)) dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel),
    .wb_dat_out(rdat), .wb_ack_out(ack), .pix_clk_out(pix), .video_out(video),
    .colour_depth_select_out(dsel), .scan_reverse_select_out(rsel), .power_out(pw));
  xgapt_panel_model panel (.mclk_in(mclk_in), .pix_clk_in(pix), .video_in(video), .power_in(pw),
    .de_len_out(de_len), .line_len_out(line_len), .lines_out(lines), .viol_out(viol), .rgb_out(rgb));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic ok(input bit c);
    chk({31'h0, c}, 32'h1);
  endtask : ok

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int v;
    v = int'(d[6:0]);
    wb(1'b1, a, d, s);
    if (a == 4'h0 && s[0]) m[0][2:0] = d[2:0];
    if (a == 4'h4 && s[0]) m[1] = (v < 5) ? 5 : (v > 100) ? 100 : v;
    for (int i = 0; i < 3; i++) if (a == 4'h8 && s[i]) m[2][8*i+:8] = d[8*i+:8];
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(rd, e);
  endtask : rdc

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cyc_n++;
    r = pw & ~pp;
    f = ~pw & pp;
    if (r[3]) t_vdd_on = cyc_n;
    if (f[3]) t_vdd_off = cyc_n;
    if (r[2]) t_led_on = cyc_n;
    if (f[2]) t_led_off = cyc_n;
    if (pw.pwm === 1'b1 && t_pwm_on == 0) t_pwm_on = cyc_n;
    if (pw.pwm === 1'b1) t_pwm_last = cyc_n;
    if (r[0]) t_bl_on = cyc_n;
    if (f[0]) t_bl_off = cyc_n;
    if (pix === 1'b1 && t_vid_on == 0) t_vid_on = cyc_n;
    if (pix === 1'b1) t_vid_last = cyc_n;
    pp = pw;
    if (cyc_n > LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    dat = 32'h0;
    sel = 4'h0;
    m = '{32'h0, 32'h32, 32'h0, 32'hD};
    duty_v = '{32'h0, 32'h4, 32'h5, 32'h64, 32'h65, 32'h7F, 32'h0};
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_rel = cyc_n;
    chk({video, pix, pw}, 32'h0);
    for (int i = 0; i < 4; i++) rdc(4'(4 * i), m[i]);
    rdc(4'h2, 32'h0);
    wr(4'h4, 32'h20, 4'h0);
    wr(4'h8, xs(), 4'hF);
    wr(4'h8, xs(), 4'h5);
    rdc(4'h4, m[1]);
    rdc(4'h8, m[2]);
    $display("test registers done");
    wr(4'h0, 32'h3, 4'h1);
    wait (t_bl_on != 0);
    ok(t_vdd_on - t_rel >= 500 * MS);
    ok((t_vid_on - t_vdd_on) inside {[30 * MS:50 * MS]});
    ok(t_bl_on - t_vid_on >= 200 * MS);
    ok(t_pwm_on > t_led_on);
    ok(t_bl_on > t_pwm_on);
    $display("test power up done");
    ln0 = lines;
    wait (lines >= ln0 + 2);
    chk(de_len, 1024);
    chk(line_len, 1344);
    chk(line_len - de_len, 320);
    chk({8'h0, rgb}, {8'h0, m[2][23:0]});
    ok(dsel === 1'b1 && rsel === 1'b0);
    wb(1'b0, 4'hC, 32'h0, 4'hF);
    chk(rd & 32'h1DF, 32'h1D6);
    wr(4'h0, 32'h5, 4'h1);
    ln0 = lines;
    wait (lines >= ln0 + 1);
    chk({8'h0, rgb}, {8'h0, m[2][23:18], 2'h0, m[2][15:10], 2'h0, m[2][7:2], 2'h0});
    ok(dsel === 1'b0 && rsel === 1'b1);
    $display("test line timing done");
    duty_v[6] = xs() % 96 + 5;
    for (int i = 0; i < 7; i++) begin
      wr(4'h4, duty_v[i], 4'h1);
      rdc(4'h4, m[1]);
      repeat (2 * PWM_PER) @(posedge mclk_in);
      hi = 0;
      repeat (PWM_PER) begin
        @(posedge mclk_in);
        hi += pw.pwm;
      end
      chk(hi, m[1]);
    end
    $display("test dimming done");
    wr(4'h4, 32'h64, 4'h1);
    wr(4'h0, 32'h2, 4'h1);
    wait (t_led_off != 0);
    ok((t_vdd_off - t_vid_last) inside {[0:50 * MS]});
    ok(t_bl_off - t_vid_last >= 200 * MS);
    ok(t_bl_off <= t_pwm_last + 1);
    ok(t_pwm_last < t_led_off);
    wb(1'b0, 4'hC, 32'h0, 4'hF);
    chk(rd & 32'h1FF, 32'hD);
    wr(4'h0, 32'h1, 4'h1);
    repeat (100 * MS) @(posedge mclk_in);
    ok(pw.vdd_en === 1'b0);
    ok(video === '0 && pix === 1'b0 && dsel === 1'b0 && rsel === 1'b0);
    chk(viol, 0);
    $display("test power down done");
    wrap_up();
  end
endmodule : tb
